// ===== logic/rptx_pkg.sv
// Constants and types for the transmit symbol conditioner
package rptx_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_TX_STATE = 8'h00;
  localparam logic [7:0] ADDR_INJ_CTL = 8'h04;
  localparam logic [7:0] ADDR_INJ_THR = 8'h08;
  localparam logic [7:0] ADDR_INJ_SYM_A = 8'h0c;
  localparam logic [7:0] ADDR_INJ_SYM_B = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  // Field positions
  localparam int MODE_LSB = 0;
  localparam int PAR_EN_BIT = 6;
  localparam int INJ_LSB = 0;
  localparam int ST_PERR_BIT = 0;
  localparam int ST_RF_LSB = 1;
  localparam int ST_LVL_LSB = 4;
  localparam int ST_CNT_LSB = 8;
  // Reset values
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic PAR_EN_RST = 1'b1;
  localparam logic [7:0] INJ_THR_RST = 8'h00;
  localparam logic [4:0] INJ_SYM_RST = 5'h00;
  // Bit slots per symbol pair
  localparam logic [3:0] BITS_PER_PAIR = 4'ha;
  // Preamble targets, in idle pairs
  localparam logic [3:0] PRE_TARGET = 4'h7;
  localparam logic [3:0] PRE_MAX = 4'hf;
  // Smoother queue: nominal fill and depth
  localparam logic [1:0] SM_NOMINAL = 2'h1;
  localparam logic [1:0] SM_DEPTH = 2'h2;
  // Five-bit line codes
  localparam logic [4:0] SYM_I = 5'h1f;
  localparam logic [4:0] SYM_H = 5'h04;
  localparam logic [4:0] SYM_Q = 5'h00;
  localparam logic [4:0] SYM_J = 5'h18;
  localparam logic [4:0] SYM_K = 5'h11;
  localparam logic [4:0] SYM_T = 5'h0d;
  localparam logic [4:0] SYM_R = 5'h07;
  localparam logic [4:0] SYM_S = 5'h19;
  typedef enum logic [2:0] {
    TM_OFF = 3'b000,
    TM_ACTIVE = 3'b001,
    TM_IDLE = 3'b010,
    TM_MASTER = 3'b011,
    TM_QUIET = 3'b100,
    TM_RSVD = 3'b101,
    TM_HALT = 3'b110,
    TM_RSVD2 = 3'b111
  } rptx_mode_e;
  typedef enum logic [1:0] {
    INJ_NONE = 2'b00,
    INJ_ONESHOT = 2'b01,
    INJ_PERIODIC = 2'b10,
    INJ_CONT = 2'b11
  } rptx_inj_e;
  typedef enum logic [2:0] {
    RF_IDLE = 3'b000,
    RF_REPEAT = 3'b001,
    RF_HALT = 3'b010,
    RF_END = 3'b011
  } rptx_rf_e;
endpackage : rptx_pkg

// ===== logic/rptx_symbol_conditioner.sv
// Transmit repeat filter, smoother, line states, injection, serializer
`timescale 1ns/100ps

module rptx_symbol_conditioner (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // APB register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Encoded symbol pairs from the upstream encoder
  input wire logic [9:0] pairIn,
  input wire logic tx_parity_fail,
  output logic pairTake,
  // Serial line toward the media transmitter
  output logic txBit,
  output logic txEnable
);

  typedef struct packed {
    logic [2:0] txMode;
    logic parEn;
    logic [1:0] injCtl;
    logic [7:0] injThr;
    logic [4:0] injA;
    logic [4:0] injB;
    logic parErr;
    rptx_pkg::rptx_rf_e rf;
    logic [1:0] lvl;
    logic [9:0] q0;
    logic [9:0] q1;
    logic [3:0] preCnt;
    logic inPre;
    logic extDone;
    logic delDone;
    logic [3:0] bitCnt;
    logic [9:0] shift;
    logic [7:0] injCnt;
    logic shotDone;
    logic txEn;
    logic [31:0] rdata;
  } rptx_state_s;

  rptx_state_s st;
  rptx_state_s next_st;

  localparam logic [9:0] PAIR_II = {rptx_pkg::SYM_I, rptx_pkg::SYM_I};
  localparam logic [9:0] PAIR_HH = {rptx_pkg::SYM_H, rptx_pkg::SYM_H};
  localparam logic [9:0] PAIR_QQ = {rptx_pkg::SYM_Q, rptx_pkg::SYM_Q};
  localparam logic [9:0] PAIR_HQ = {rptx_pkg::SYM_H, rptx_pkg::SYM_Q};
  localparam logic [9:0] PAIR_JK = {rptx_pkg::SYM_J, rptx_pkg::SYM_K};

  // Sixteen data codes; anything else not a known control is a violation
  function automatic logic isData(input logic [4:0] s);
    case (s)
      5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
      5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d: begin
        isData = 1'b1;
      end
      default: begin
        isData = 1'b0;
      end
    endcase
  endfunction : isData

  // Halt and Quiet inside a frame count as violations
  function automatic logic isLegal(input logic [4:0] s);
    isLegal = isData(s) || s == rptx_pkg::SYM_I || s == rptx_pkg::SYM_J
      || s == rptx_pkg::SYM_K || s == rptx_pkg::SYM_T
      || s == rptx_pkg::SYM_R || s == rptx_pkg::SYM_S;
  endfunction : isLegal

  function automatic logic isRS(input logic [4:0] s);
    isRS = s == rptx_pkg::SYM_R || s == rptx_pkg::SYM_S;
  endfunction : isRS

  logic byteSlot;
  logic [4:0] symA;
  logic [4:0] symB;
  logic pairJK;
  logic pairViol;
  logic leadIdle;
  logic forceIdle;
  logic [9:0] rfOut;
  logic [9:0] smIn;
  logic [9:0] smOut;
  logic [9:0] lsgOut;
  logic [9:0] finalOut;
  logic injHit;
  logic setup;
  logic access;
  logic mapped;
  logic [31:0] statusWord;

  assign byteSlot = st.bitCnt == rptx_pkg::BITS_PER_PAIR - 4'h1;
  assign symA = pairIn[9:5];
  assign symB = pairIn[4:0];
  assign pairJK = pairIn == PAIR_JK;
  assign leadIdle = symA == rptx_pkg::SYM_I;
  assign pairViol = !isLegal(symA) || !isLegal(symB)
    || (tx_parity_fail && st.parEn);
  assign forceIdle = st.txMode != rptx_pkg::TM_ACTIVE;
  assign pairTake = byteSlot;
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign mapped = paddr == rptx_pkg::ADDR_TX_STATE
    || paddr == rptx_pkg::ADDR_INJ_CTL || paddr == rptx_pkg::ADDR_INJ_THR
    || paddr == rptx_pkg::ADDR_INJ_SYM_A || paddr == rptx_pkg::ADDR_INJ_SYM_B
    || paddr == rptx_pkg::ADDR_STATUS;
  assign pready = access;
  assign pslverr = access && !mapped;
  assign prdata = st.rdata;
  assign txBit = st.shift[9];
  assign txEnable = st.txEn;

  always_comb begin
    statusWord = 32'h0;
    statusWord[rptx_pkg::ST_PERR_BIT] = st.parErr;
    statusWord[rptx_pkg::ST_RF_LSB +: 3] = st.rf;
    statusWord[rptx_pkg::ST_LVL_LSB +: 2] = st.lvl;
    statusWord[rptx_pkg::ST_CNT_LSB +: 4] = st.preCnt;
  end

  // Line state generator patterns
  always_comb begin
    case (st.txMode)
      rptx_pkg::TM_IDLE: begin
        lsgOut = PAIR_II;
      end
      rptx_pkg::TM_MASTER: begin
        lsgOut = PAIR_HQ;
      end
      rptx_pkg::TM_HALT: begin
        lsgOut = PAIR_HH;
      end
      rptx_pkg::TM_QUIET, rptx_pkg::TM_OFF: begin
        lsgOut = PAIR_QQ;
      end
      default: begin
        lsgOut = PAIR_QQ;
      end
    endcase
  end

  always_comb begin
    next_st = st;
    rfOut = PAIR_II;
    smIn = PAIR_II;
    smOut = PAIR_II;
    finalOut = PAIR_QQ;
    injHit = 1'b0;
    next_st.bitCnt = byteSlot ? 4'h0 : st.bitCnt + 4'h1;
    next_st.shift = {st.shift[8:0], 1'b0};
    next_st.txEn = st.txMode != rptx_pkg::TM_OFF;

    if (byteSlot) begin
      // Repeat filter
      if (forceIdle) begin
        next_st.rf = rptx_pkg::RF_IDLE;
        rfOut = PAIR_II;
      end else if (pairJK) begin
        next_st.rf = rptx_pkg::RF_REPEAT;
        rfOut = pairIn;
      end else begin
        case (st.rf)
          rptx_pkg::RF_REPEAT: begin
            // R or S right before T in one pair is caught here
            if (pairViol || (isRS(symA) && symB == rptx_pkg::SYM_T)) begin
              next_st.rf = rptx_pkg::RF_HALT;
              rfOut = PAIR_HH;
            end else if (leadIdle) begin
              next_st.rf = rptx_pkg::RF_IDLE;
            end else if (isRS(symA) || isRS(symB)) begin
              next_st.rf = rptx_pkg::RF_END;
              rfOut = pairIn;
            end else begin
              rfOut = pairIn; // NT stays here as a clean ending
            end
          end
          rptx_pkg::RF_END: begin
            if (pairViol || symA == rptx_pkg::SYM_T
                || symB == rptx_pkg::SYM_T) begin
              next_st.rf = rptx_pkg::RF_HALT;
              rfOut = PAIR_HH;
            end else if (leadIdle) begin
              next_st.rf = rptx_pkg::RF_IDLE;
            end else begin
              rfOut = pairIn;
            end
          end
          rptx_pkg::RF_HALT: begin
            // First Halt pair replaced the violation; this is the second unless the pair leads with Idle
            next_st.rf = rptx_pkg::RF_IDLE;
            if (!leadIdle) begin
              rfOut = PAIR_HH;
            end
          end
          default: begin
            rfOut = PAIR_II;
          end
        endcase
      end

      // Smoother: small queue lets a pair be added or dropped
      smIn = rfOut;
      if (smIn == PAIR_JK && st.inPre && st.preCnt < rptx_pkg::PRE_TARGET
          && !st.extDone && st.lvl < rptx_pkg::SM_DEPTH) begin
        smOut = PAIR_II;
        next_st.extDone = 1'b1;
        next_st.preCnt = st.preCnt + 4'h1;
        if (st.lvl == 2'h0) begin
          next_st.q0 = smIn;
        end else begin
          next_st.q1 = smIn;
        end
        next_st.lvl = st.lvl + 2'h1;
      end else if (smIn == PAIR_II && st.preCnt >= rptx_pkg::PRE_TARGET
          && !st.delDone && st.lvl != 2'h0 && st.q0 == PAIR_II) begin
        smOut = st.q0;
        next_st.delDone = 1'b1;
        next_st.q0 = st.q1;
        next_st.lvl = st.lvl - 2'h1;
      end else begin
        smOut = (st.lvl == 2'h0) ? smIn : st.q0;
        if (st.lvl == 2'h1) begin
          next_st.q0 = smIn;
        end else if (st.lvl == rptx_pkg::SM_DEPTH) begin
          next_st.q0 = st.q1;
          next_st.q1 = smIn;
        end
      end
      // Count idles actually sent; keeps six or more at the far end
      if (smOut == PAIR_II) begin
        next_st.inPre = 1'b1;
        if (st.preCnt != rptx_pkg::PRE_MAX) begin
          next_st.preCnt = st.preCnt + 4'h1;
        end
      end else if (smOut == PAIR_JK) begin
        next_st.inPre = 1'b0;
        next_st.preCnt = 4'h0;
        next_st.extDone = 1'b0;
        next_st.delDone = 1'b0;
      end

      // Injection position of this pair; the JK itself is zero
      if (smOut == PAIR_JK) begin
        next_st.injCnt = 8'h0;
        next_st.shotDone = 1'b0;
      end else if (st.injCnt != 8'hff) begin
        next_st.injCnt = st.injCnt + 8'h1;
      end
      case (st.injCtl)
        rptx_pkg::INJ_ONESHOT: begin
          injHit = next_st.injCnt == st.injThr && !next_st.shotDone;
          if (injHit) begin
            next_st.shotDone = 1'b1;
          end
        end
        rptx_pkg::INJ_PERIODIC: begin
          injHit = next_st.injCnt >= st.injThr;
          if (injHit) begin
            next_st.injCnt = 8'h0;
          end
        end
        rptx_pkg::INJ_CONT: begin
          injHit = 1'b1;
        end
        default: begin
          injHit = 1'b0;
        end
      endcase

      // Output priority: injection, then line state, then filter path
      if (injHit) begin
        finalOut = {st.injA, st.injB};
      end else if (forceIdle) begin
        finalOut = lsgOut;
      end else begin
        finalOut = smOut;
      end
      next_st.shift = finalOut;
    end

    // Sticky parity flag; a new failure wins over a clear
    if (access && pwrite && paddr == rptx_pkg::ADDR_STATUS && pstrb[0]
        && pwdata[rptx_pkg::ST_PERR_BIT]) begin
      next_st.parErr = 1'b0;
    end
    if (byteSlot && tx_parity_fail && st.parEn) begin
      next_st.parErr = 1'b1;
    end

    // Register writes take effect in the access phase
    if (access && pwrite && pstrb[0]) begin
      case (paddr)
        rptx_pkg::ADDR_TX_STATE: begin
          next_st.txMode = pwdata[rptx_pkg::MODE_LSB +: 3];
          next_st.parEn = pwdata[rptx_pkg::PAR_EN_BIT];
        end
        rptx_pkg::ADDR_INJ_CTL: begin
          next_st.injCtl = pwdata[rptx_pkg::INJ_LSB +: 2];
        end
        rptx_pkg::ADDR_INJ_THR: begin
          next_st.injThr = pwdata[7:0];
        end
        rptx_pkg::ADDR_INJ_SYM_A: begin
          next_st.injA = pwdata[4:0];
        end
        rptx_pkg::ADDR_INJ_SYM_B: begin
          next_st.injB = pwdata[4:0];
        end
        default: begin
        end
      endcase
    end

    // Read data captured in setup so it stands for the access phase
    if (setup) begin
      case (paddr)
        rptx_pkg::ADDR_TX_STATE: begin
          next_st.rdata = {25'h0, st.parEn, 3'h0, st.txMode};
        end
        rptx_pkg::ADDR_INJ_CTL: begin
          next_st.rdata = {30'h0, st.injCtl};
        end
        rptx_pkg::ADDR_INJ_THR: begin
          next_st.rdata = {24'h0, st.injThr};
        end
        rptx_pkg::ADDR_INJ_SYM_A: begin
          next_st.rdata = {27'h0, st.injA};
        end
        rptx_pkg::ADDR_INJ_SYM_B: begin
          next_st.rdata = {27'h0, st.injB};
        end
        rptx_pkg::ADDR_STATUS: begin
          next_st.rdata = statusWord;
        end
        default: begin
          next_st.rdata = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st <= '0;
      st.txMode <= rptx_pkg::MODE_RST;
      st.parEn <= rptx_pkg::PAR_EN_RST;
      st.injThr <= rptx_pkg::INJ_THR_RST;
      st.injA <= rptx_pkg::INJ_SYM_RST;
      st.injB <= rptx_pkg::INJ_SYM_RST;
      st.rf <= rptx_pkg::RF_IDLE;
      st.lvl <= rptx_pkg::SM_NOMINAL;
      st.q0 <= PAIR_II;
      st.q1 <= PAIR_II;
      st.shift <= PAIR_QQ;
    end else begin
      st <= next_st;
    end
  end

endmodule : rptx_symbol_conditioner

// ===== testbench/rptx_checker_asserts.sv
// Port-level assertions for the transmit symbol conditioner
`timescale 1ns/100ps

module rptx_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // APB port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Symbol side
  input wire logic pairTake,
  input wire logic txBit,
  input wire logic txEnable
);
  logic [2:0] mode;
  logic [1:0] inj;
  logic [5:0] age;
  logic wr;
  logic bad;
  assign wr = psel & penable & pwrite & pstrb[0];
  assign bad = paddr > rptx_pkg::ADDR_STATUS || paddr[1:0] != 2'h0;
  // Shadow of the mode fields, age since the last write
  always_ff @(posedge clock) begin
    if (srst) begin
      mode <= 3'h0;
      inj <= 2'h0;
      age <= 6'h00;
    end else begin
      if (wr && paddr == rptx_pkg::ADDR_TX_STATE) mode <= pwdata[2:0];
      if (wr && paddr == rptx_pkg::ADDR_INJ_CTL) inj <= pwdata[1:0];
      if (wr) age <= 6'h00;
      else if (age != 6'h3f) age <= age + 6'h01;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence seqGap;
    (!pairTake) [*8] ##1 !pairTake;
  endsequence
  chk_take_period: assert property (
    pairTake |=> seqGap ##1 pairTake) else $error("pair slot spacing wrong");
  chk_apb_ready: assert property (psel && penable |-> pready)
    else $error("pready missing in access");
  chk_ready_idle: assert property (!penable |-> !pready)
    else $error("pready outside access");
  chk_slverr_map: assert property (psel && penable && bad |-> pslverr)
    else $error("no error on unmapped address");
  chk_slverr_ok: assert property (psel && penable && !bad |-> !pslverr)
    else $error("error on mapped address");
  chk_rdata_zero: assert property (psel && penable && !pwrite && bad
    |-> prdata == 32'h0) else $error("unmapped read not zero");
  chk_off_disable: assert property (
    mode == 3'h0 && $past(mode) == 3'h0 |-> !txEnable)
    else $error("enable high in off mode");
  chk_on_enable: assert property (
    mode == 3'h1 && $past(mode) == 3'h1 |-> txEnable)
    else $error("enable low in active mode");
  chk_quiet_line: assert property (
    age > 6'h28 && inj == 2'h0 && mode inside {3'h0, 3'h4, 3'h5, 3'h7}
    |-> !txBit) else $error("line not quiet");
  chk_idle_line: assert property (
    age > 6'h28 && inj == 2'h0 && mode == 3'h2 |-> txBit)
    else $error("line not idle");
endmodule : rptx_checker

bind rptx_symbol_conditioner rptx_checker u_chk (.clock(clock),
  .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pairTake(pairTake),
  .txBit(txBit), .txEnable(txEnable));

// ===== testbench/rptx_media_tx_model.sv
// Media transmitter model: deserializes the outgoing line
`timescale 1ns/100ps

module rptx_media_tx_model (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Line
  input wire logic txBit,
  input wire logic txEnable,
  input wire logic pairTake,
  // Recovered pairs
  output logic [9:0] rxPair,
  output logic rxValid
);
  logic [8:0] sh = 9'h000;
  // Last bit of a pair lands on the next slot edge
  always @(posedge clock) begin
    sh <= {sh[7:0], txBit};
    rxValid <= pairTake & ~srst;
    if (pairTake) rxPair <= {sh, txBit};
  end
endmodule : rptx_media_tx_model

// ===== testbench/test_rptx_symbol_conditioner.sv
// Self-checking bench for the transmit symbol conditioner
`timescale 1ns/100ps

module test_rptx_symbol_conditioner;
  localparam logic [9:0] PI = {rptx_pkg::SYM_I, rptx_pkg::SYM_I};
  localparam logic [9:0] PH = {rptx_pkg::SYM_H, rptx_pkg::SYM_H};
  localparam logic [9:0] PJK = {rptx_pkg::SYM_J, rptx_pkg::SYM_K};
  localparam logic [9:0] PD = 10'h12a;
  localparam logic [9:0] PA = 10'h2b6;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [9:0] pairIn = PI;
  logic tx_parity_fail = 1'b0;
  logic pairTake;
  logic txBit;
  logic txEnable;
  logic [9:0] rxPair;
  logic rxValid;
  logic [10:0] feedQ[$];
  logic [9:0] rxLog[$];
  int err_count = 0;
  int compares = 0;

  always #25 clock = ~clock;

  rptx_symbol_conditioner u_dut (.clock(clock), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pairIn(pairIn), .tx_parity_fail(tx_parity_fail),
    .pairTake(pairTake), .txBit(txBit), .txEnable(txEnable));
  rptx_media_tx_model u_media (.clock(clock), .srst(srst), .txBit(txBit),
    .txEnable(txEnable), .pairTake(pairTake), .rxPair(rxPair),
    .rxValid(rxValid));

  // Upstream feeder: next pair set up right after each take
  always @(posedge clock) begin
    if (rxValid) rxLog.push_back(rxPair);
    if (pairTake) begin
      if (feedQ.size() > 0) {tx_parity_fail, pairIn} <= feedQ.pop_front();
      else {tx_parity_fail, pairIn} <= {1'b0, PI};
    end
  end

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
    output logic [31:0] rd, output logic er);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, rd, er);
  endtask : wr

  task automatic waitSlots(int n);
    repeat (n * 10) @(posedge clock);
  endtask : waitSlots

  // Index of three consecutive pairs at or after from, else -1
  function automatic int findAt(int from, logic [29:0] pat);
    for (int i = from; i + 2 < rxLog.size(); i++)
      if ({rxLog[i], rxLog[i + 1], rxLog[i + 2]} === pat) return i;
    return -1;
  endfunction : findAt

  task automatic testReset;
    logic [31:0] rd;
    logic er;
    apb(1'b0, rptx_pkg::ADDR_TX_STATE, 32'h0, rd, er);
    check("tx_state_reg", rd, 32'h40);
    apb(1'b0, rptx_pkg::ADDR_INJ_THR, 32'h0, rd, er);
    check("inject_threshold", rd, 32'h0);
    apb(1'b1, 8'h40, 32'h7, rd, er);
    check("unmapped error", {31'h0, er}, 32'h1);
    apb(1'b0, 8'h40, 32'h0, rd, er);
    check("unmapped read", rd, 32'h0);
    check("off enable", {31'h0, txEnable}, 32'h0);
    check("off line", {22'h0, rxLog[$]}, 32'h0);
  endtask : testReset

  task automatic testModes;
    logic [9:0] pat[8];
    pat = '{10'h000, 10'h000, PI, {rptx_pkg::SYM_H, rptx_pkg::SYM_Q},
      10'h000, 10'h000, PH, 10'h000};
    for (int m = 7; m >= 0; m--) begin
      if (m == 1) continue;
      wr(rptx_pkg::ADDR_TX_STATE, 32'h40 | m);
      waitSlots(5);
      check("mode line", {22'h0, rxLog[$]},
        {22'h0, pat[m]});
      check("mode enable", {31'h0, txEnable}, {31'h0, m != 0});
    end
  endtask : testModes

  task automatic testFilter;
    logic [10:0] bad[4];
    int j;
    bad = '{{1'b0, 5'h01, 5'h09}, {1'b1, PD},
      {1'b0, rptx_pkg::SYM_R, rptx_pkg::SYM_T},
      {1'b0, 5'h09, rptx_pkg::SYM_S}};
    wr(rptx_pkg::ADDR_TX_STATE, 32'h41);
    for (int k = 0; k < 4; k++) begin
      rxLog.delete();
      repeat (3) feedQ.push_back({1'b0, PD});
      repeat (3) feedQ.push_back({1'b0, PI});
      feedQ.push_back({1'b0, PJK});
      repeat (3) feedQ.push_back({1'b0, PD});
      feedQ.push_back(bad[k]);
      // Last case: S passes, then a T in the next pair is a violation
      feedQ.push_back(k == 3 ? {1'b0, rptx_pkg::SYM_T, 5'h09} : {1'b0, PD});
      repeat (3) feedQ.push_back({1'b0, PD});
      waitSlots(22);
      j = findAt(0, {PJK, PD, PD});
      check("data after start", findAt(0, {PD, PD, PD}),
        j + 1);
      check("halt slot", findAt(j, {PH, PH, PI}),
        j + 4 + (k == 3));
    end
  endtask : testFilter

  task automatic testInject;
    int j;
    int n;
    wr(rptx_pkg::ADDR_INJ_SYM_A, {27'h0, PA[9:5]});
    wr(rptx_pkg::ADDR_INJ_SYM_B, {27'h0, PA[4:0]});
    wr(rptx_pkg::ADDR_TX_STATE, 32'h42);
    wr(rptx_pkg::ADDR_INJ_CTL, 32'h3);
    waitSlots(5);
    check("continuous", {22'h0, rxLog[$]}, {22'h0, PA});
    wr(rptx_pkg::ADDR_INJ_CTL, 32'h0);
    waitSlots(5);
    check("no injection", {22'h0, rxLog[$]}, {22'h0, PI});
    wr(rptx_pkg::ADDR_TX_STATE, 32'h41);
    wr(rptx_pkg::ADDR_INJ_THR, 32'h3);
    for (int c = 1; c < 3; c++) begin
      wr(rptx_pkg::ADDR_INJ_CTL, c);
      rxLog.delete();
      repeat (3) feedQ.push_back({1'b0, PI});
      feedQ.push_back({1'b0, PJK});
      repeat (9) feedQ.push_back({1'b0, PD});
      waitSlots(18);
      j = findAt(0, {PJK, PD, PD});
      n = 0;
      for (int i = j; i < j + 10; i++) n += (rxLog[i] === PA);
      check("inject slot", {22'h0, rxLog[j + 3]},
        {22'h0, PA});
      check("inject count", n, (c == 1) ? 1 : 3);
    end
  endtask : testInject

  // Short preamble gains one idle pair, long one loses one
  task automatic testSmooth;
    int j1;
    int j2;
    int j3;
    wr(rptx_pkg::ADDR_INJ_CTL, 32'h0);
    rxLog.delete();
    for (int f = 0; f < 3; f++) begin
      feedQ.push_back({1'b0, PJK});
      repeat (2) feedQ.push_back({1'b0, PD});
      if (f == 0) repeat (3) feedQ.push_back({1'b0, PI});
      if (f == 1) repeat (10) feedQ.push_back({1'b0, PI});
    end
    waitSlots(30);
    j1 = findAt(0, {PJK, PD, PD});
    j2 = findAt(j1 + 1, {PJK, PD, PD});
    j3 = findAt(j2 + 1, {PJK, PD, PD});
    check("short preamble", j2 - j1, 3 + 4);
    check("long preamble", j3 - j2, 3 + 9);
  endtask : testSmooth

  task automatic stop_test;
    $display("Checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  initial begin
    repeat (30000) @(posedge clock);
    err_count++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    waitSlots(4);
    testReset();
    testModes();
    testFilter();
    testInject();
    testSmooth();
    stop_test();
  end
endmodule : test_rptx_symbol_conditioner
